// [rtl/afe_pkg.sv]
package afe_pkg;
   // register map geometry
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned REG_W = 24;
   localparam int unsigned NCH = 3;
   localparam logic [4:0] ADDR_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_CFG0 = 5'h0D;
   localparam logic [4:0] MAP_FIRST = 5'h00;
   localparam logic [4:0] MAP_LAST = 5'h1F;
   localparam logic [4:0] DATA_TYPE_LAST = 5'h07;
   localparam logic [4:0] WR_FIRST = 5'h08;
   localparam logic [4:0] GROUP_MASK = 5'h18;
   // reset values
   localparam logic [23:0] STATUS_RST = 24'hA90007;
   localparam logic [23:0] CFG0_RST = 24'h386050;
   // status field positions
   localparam int unsigned ST_READ_LO = 22;
   localparam int unsigned ST_WRITE = 21;
   localparam int unsigned ST_FLOAT = 20;
   localparam int unsigned ST_MERGE = 19;
   localparam int unsigned ST_CRCW = 18;
   localparam int unsigned ST_DATAW_LO = 16;
   localparam int unsigned ST_CRCEN = 15;
   localparam int unsigned ST_INTEN = 14;
   // config zero field positions
   localparam int unsigned C0_OFFEN = 23;
   localparam int unsigned C0_GAINEN = 22;
   localparam int unsigned C0_IDLE_TONE_NOISE_LEVEL_LO = 20;
   localparam int unsigned C0_BIAS_LO = 18;
   localparam int unsigned C0_PRE_LO = 16;
   localparam int unsigned C0_OSR_LO = 13;
   localparam int unsigned C0_TRIM_LO = 0;
   // keys and counts
   localparam logic [7:0] LOCK_PASSWORD = 8'hA5;
   localparam logic [4:0] GAIN_DELAY_MODULATOR_DIGITAL_CLOCK = 5'd24;
   localparam logic [1:0] ANALOG_SAMPLE_CLOCK_PER_MODULATOR_DIGITAL_CLOCK = 2'd3;
   localparam logic [2:0] READY_PULSE_CYCLES = 3'd4;
   localparam logic [5:0] CRC_BITS_SHORT = 6'd16;
   localparam logic [5:0] CRC_BITS_LONG = 6'd32;
   // read pointer modes
   typedef enum logic [1:0] {
      AFE_RD_HOLD,
      AFE_RD_GROUP,
      AFE_RD_TYPE,
      AFE_RD_MAP
   } afe_rd_mode_e;
endpackage

// [rtl/afe_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
module afe_clk_div
   import afe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] presc,
   output logic analog_sample_clock_tick,
   output logic modulator_digital_clock_tick
);
   logic [2:0] div_q;
   logic [2:0] div_last;
   logic [1:0] dm_q;

   // divide by 1, 2, 4 or 8
   always_comb begin
      case (presc)
         2'b11: div_last = 3'd7;
         2'b10: div_last = 3'd3;
         2'b01: div_last = 3'd1;
         default: div_last = 3'd0;
      endcase
   end

   // analog sample clock tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 3'd0;
         analog_sample_clock_tick <= 1'b0;
      end else if (div_q >= div_last) begin
         div_q <= 3'd0;
         analog_sample_clock_tick <= 1'b1;
      end else begin
         div_q <= div_q + 3'd1;
         analog_sample_clock_tick <= 1'b0;
      end
   end

   // modulator clock tick from analog ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dm_q <= 2'd0;
         modulator_digital_clock_tick <= 1'b0;
      end else begin
         modulator_digital_clock_tick <= analog_sample_clock_tick && (dm_q == ANALOG_SAMPLE_CLOCK_PER_MODULATOR_DIGITAL_CLOCK);
         if (analog_sample_clock_tick) begin
            dm_q <= (dm_q == ANALOG_SAMPLE_CLOCK_PER_MODULATOR_DIGITAL_CLOCK) ? 2'd0 : dm_q + 2'd1;
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/afe_ready_delay.sv]
`timescale 1ns/1ps
`default_nettype none
module afe_ready_delay
   import afe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic conv_done,
   input wire logic gain_on,
   input wire logic dm_tick,
   output logic ready_pulse
);
   logic busy_q;
   logic [4:0] cnt_q;

   // hold a result for 24 modulator periods when gain correction is on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 5'd0;
         ready_pulse <= 1'b0;
      end else begin
         ready_pulse <= 1'b0;
         if (conv_done && !gain_on) begin
            ready_pulse <= 1'b1;
            busy_q <= 1'b0;
         end else if (conv_done) begin
            busy_q <= 1'b1;
            cnt_q <= 5'd0;
         end else if (busy_q && dm_tick) begin
            if (cnt_q == GAIN_DELAY_MODULATOR_DIGITAL_CLOCK - 5'd1) begin
               busy_q <= 1'b0;
               ready_pulse <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 5'd1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/afe_status_config_regs.sv]
// How it works
// - read pointer wraps over map, type, group, or holds, per read field
// - write pointer advances and wraps over writable map, or holds when bit clear
// - idle ready pin driven high when float bit set, else released
// - merge bit gives one pulse after the last channel, else one per channel
// - crc width bit selects 32-bit field with zero tail, else 16-bit
// - data width field formats words: sign-extend, zero-pad, 24-bit, rounded 16-bit
// - comm checksum enable appends checksum to each sequence, off at reset
// - with interrupt enabled a checksum error holds the ready pin low
// - interrupt clears when lock key equals password; software writes it
// - interrupt disabled: checksum still readable, no interrupt raised
// - one ready flag per channel in bits 2..0, 1 means not ready
// - reading the status register returns all ready flags to 1, except a channel whose new result arrives in that cycle
// - reading channel data leaves its ready flag alone
// - offset correction enable applies offset with no delay, off at reset
// - gain correction adds 24 modulator periods delay to the ready pulses only, not to sample_word
// - idle_tone_noise_level field sets strength: max, medium, min, off
// - bias field selects current: double, nominal, two thirds, half
// - prescaler field divides master clock by 8, 4, 2 or 1
// - three-bit ratio field selects oversampling 32 to 4096
`timescale 1ns/1ps
`default_nettype none
module afe_status_config_regs
   import afe_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_start,
   input wire logic [afe_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic reg_wr,
   input wire logic [afe_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_rd,
   output logic [afe_pkg::REG_W-1:0] reg_rdata,
   output logic [afe_pkg::ADDR_W-1:0] addr_ptr,
   input wire logic [afe_pkg::NCH-1:0] conv_done,
   input wire logic checksum_error,
   input wire logic [7:0] lock_key,
   input wire logic [23:0] sample_in,
   output logic [31:0] sample_word,
   output logic [5:0] data_word_bits,
   output logic [5:0] crc_field_bits,
   output logic comm_checksum_enable,
   output logic offset_correction_enable,
   output logic gain_correction_enable,
   output logic [1:0] idle_tone_noise_level,
   output logic [1:0] bias_current_select,
   output logic [2:0] oversampling_ratio,
   output logic [7:0] reference_tempco_trim,
   output logic analog_sample_clock,
   output logic modulator_digital_clock,
   output logic config_int_pending,
   output logic conversion_ready_pin_out,
   output logic conversion_ready_pin_oe
);
   logic rst_s1_q;
   logic rst_n_q;
   logic [23:0] status_q;
   logic [23:0] cfg0_q;
   logic [NCH-1:0] ready_flags_q;
   logic [ADDR_W-1:0] ptr_q;
   logic [ADDR_W-1:0] ptr_d;
   logic wr_access;
   logic int_q;
   logic [NCH-1:0] chan_pulse;
   logic [NCH-1:0] pending_q;
   logic fire;
   logic [2:0] low_cnt_q;
   logic [ADDR_W-1:0] lo_bound;
   logic [ADDR_W-1:0] hi_bound;
   afe_rd_mode_e rd_mode;
   logic analog_sample_clock_tick;
   logic modulator_digital_clock_tick;

   // reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   assign rd_mode = afe_rd_mode_e'(status_q[ST_READ_LO +: 2]);
   // a write steps by the write rules, any other access by the read rules
   assign wr_access = reg_wr;

   // wrap window of the pointer for the current access kind
   always_comb begin
      lo_bound = MAP_FIRST;
      hi_bound = MAP_LAST;
      if (wr_access) begin
         lo_bound = WR_FIRST;
      end else begin
         case (rd_mode)
            AFE_RD_MAP: begin
               lo_bound = MAP_FIRST;
            end
            AFE_RD_TYPE: begin
               if (ptr_q <= DATA_TYPE_LAST) begin
                  hi_bound = DATA_TYPE_LAST;
               end else begin
                  lo_bound = DATA_TYPE_LAST + 5'd1;
               end
            end
            AFE_RD_GROUP: begin
               lo_bound = ptr_q & GROUP_MASK;
               hi_bound = (ptr_q & GROUP_MASK) | ~GROUP_MASK;
            end
            default: begin
               lo_bound = ptr_q;
               hi_bound = ptr_q;
            end
         endcase
      end
   end

   // next pointer after one word
   always_comb begin
      ptr_d = ptr_q;
      if (wr_access && !status_q[ST_WRITE]) begin
         ptr_d = ptr_q;
      end else if (!wr_access && rd_mode == AFE_RD_HOLD) begin
         ptr_d = ptr_q;
      end else if (ptr_q >= hi_bound) begin
         ptr_d = lo_bound;
      end else begin
         ptr_d = ptr_q + 5'd1;
      end
   end

   // address counter
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ptr_q <= MAP_FIRST;
      end else if (cmd_start) begin
         ptr_q <= cmd_addr;
      end else if (reg_wr) begin
         ptr_q <= ptr_d;
      end else if (reg_rd) begin
         ptr_q <= ptr_d;
      end
   end
   assign addr_ptr = ptr_q;

   // control fields of the status register
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         status_q <= STATUS_RST;
      end else if (reg_wr && ptr_q == ADDR_STATUS) begin
         status_q[23:16] <= reg_wdata[23:16];
         status_q[ST_CRCEN] <= reg_wdata[ST_CRCEN];
         status_q[ST_INTEN] <= reg_wdata[ST_INTEN];
      end
   end

   // config zero register
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg0_q <= CFG0_RST;
      end else if (reg_wr && ptr_q == ADDR_CFG0) begin
         cfg0_q <= reg_wdata & 24'hFFE0FF;
      end
   end

   // per channel ready flags, a new result wins over a status read
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ready_flags_q <= 3'h7;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (chan_pulse[i]) begin
               ready_flags_q[i] <= 1'b0;
            end else if (reg_rd && ptr_q == ADDR_STATUS) begin
               ready_flags_q[i] <= 1'b1;
            end
         end
      end
   end

   // read data, unused bits zero
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata <= 24'h000000;
      end else if (reg_rd) begin
         case (ptr_q)
            ADDR_STATUS: reg_rdata <= {status_q[23:14], 11'h000, ready_flags_q};
            ADDR_CFG0: reg_rdata <= cfg0_q;
            default: reg_rdata <= 24'h000000;
         endcase
      end
   end

   // configuration checksum interrupt, set wins over clear
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         int_q <= 1'b0;
      end else if (checksum_error && status_q[ST_INTEN]) begin
         int_q <= 1'b1;
      end else if (lock_key == LOCK_PASSWORD) begin
         int_q <= 1'b0;
      end
   end
   assign config_int_pending = int_q;

   // clock ticks and delayed per channel ready pulses
   afe_clk_div u_div (
      .clk(clk),
      .rst_n(rst_n_q),
      .presc(cfg0_q[C0_PRE_LO +: 2]),
      .analog_sample_clock_tick(analog_sample_clock_tick),
      .modulator_digital_clock_tick(modulator_digital_clock_tick)
   );
   assign analog_sample_clock = analog_sample_clock_tick;
   assign modulator_digital_clock = modulator_digital_clock_tick;

   for (genvar c = 0; c < NCH; c++) begin : g_dly
      afe_ready_delay u_dly (
         .clk(clk),
         .rst_n(rst_n_q),
         .conv_done(conv_done[c]),
         .gain_on(cfg0_q[C0_GAINEN]),
         .dm_tick(modulator_digital_clock_tick),
         .ready_pulse(chan_pulse[c])
      );
   end

   // merge channels into one pulse at the last arrival
   assign fire = status_q[ST_MERGE] ? &(pending_q | chan_pulse) : |chan_pulse;
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pending_q <= 3'h0;
      end else if (!status_q[ST_MERGE] || fire) begin
         pending_q <= 3'h0;
      end else begin
         pending_q <= pending_q | chan_pulse;
      end
   end

   // active low pulse length
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         low_cnt_q <= 3'd0;
      end else if (fire) begin
         low_cnt_q <= READY_PULSE_CYCLES;
      end else if (low_cnt_q != 3'd0) begin
         low_cnt_q <= low_cnt_q - 3'd1;
      end
   end

   // ready pin drive
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         conversion_ready_pin_out <= 1'b1;
         conversion_ready_pin_oe <= 1'b0;
      end else if (int_q || fire || low_cnt_q > 3'd1) begin
         conversion_ready_pin_out <= 1'b0;
         conversion_ready_pin_oe <= 1'b1;
      end else begin
         conversion_ready_pin_out <= 1'b1;
         conversion_ready_pin_oe <= status_q[ST_FLOAT];
      end
   end

   // output word formatting
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sample_word <= 32'h00000000;
      end else begin
         case (status_q[ST_DATAW_LO +: 2])
            2'b11: sample_word <= {{8{sample_in[23]}}, sample_in};
            2'b10: sample_word <= {sample_in, 8'h00};
            2'b01: sample_word <= {8'h00, sample_in};
            default: begin
               if (sample_in[7] && sample_in[23:8] != 16'h7FFF) begin
                  sample_word <= {16'h0000, sample_in[23:8] + 16'h0001};
               end else begin
                  sample_word <= {16'h0000, sample_in[23:8]};
               end
            end
         endcase
      end
   end

   // word widths for the serial framer
   always_comb begin
      case (status_q[ST_DATAW_LO +: 2])
         2'b11, 2'b10: data_word_bits = 6'd32;
         2'b01: data_word_bits = 6'd24;
         default: data_word_bits = 6'd16;
      endcase
   end
   assign crc_field_bits = status_q[ST_CRCW] ? CRC_BITS_LONG : CRC_BITS_SHORT;
   assign comm_checksum_enable = status_q[ST_CRCEN];

   // converter settings
   assign offset_correction_enable = cfg0_q[C0_OFFEN];
   assign gain_correction_enable = cfg0_q[C0_GAINEN];
   assign idle_tone_noise_level = cfg0_q[C0_IDLE_TONE_NOISE_LEVEL_LO +: 2];
   assign bias_current_select = cfg0_q[C0_BIAS_LO +: 2];
   assign oversampling_ratio = cfg0_q[C0_OSR_LO +: 3];
   assign reference_tempco_trim = cfg0_q[C0_TRIM_LO +: 8];
endmodule
`default_nettype wire

// [verif/afe_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module afe_regs_checker
   import afe_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_start,
   input wire logic [afe_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [afe_pkg::ADDR_W-1:0] addr_ptr,
   input wire logic [afe_pkg::NCH-1:0] conv_done,
   input wire logic checksum_error,
   input wire logic [7:0] lock_key,
   input wire logic [5:0] data_word_bits,
   input wire logic [5:0] crc_field_bits,
   input wire logic gain_correction_enable,
   input wire logic modulator_digital_clock,
   input wire logic config_int_pending,
   input wire logic conversion_ready_pin_out,
   input wire logic conversion_ready_pin_oe
);
   import afe_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // pointer moves only on a request
   chk_cmd_load: assert property (cmd_start |=> addr_ptr == $past(cmd_addr))
      else $error("pointer not loaded from start address");
   chk_ptr_still: assert property (!cmd_start && !reg_rd && !reg_wr |=> $stable(addr_ptr))
      else $error("pointer moved without a request");
   // derived clocks
   chk_dm_spacing: assert property (modulator_digital_clock |=> !modulator_digital_clock[*3])
      else $error("modulator ticks too close");
   // word formats
   chk_width_codes: assert property ((crc_field_bits == CRC_BITS_SHORT ||
      crc_field_bits == CRC_BITS_LONG) && data_word_bits inside {6'd16, 6'd24, 6'd32})
      else $error("illegal word width");
   // interrupt flag and pin
   chk_int_hold: assert property (config_int_pending && lock_key != LOCK_PASSWORD |=>
      config_int_pending)
      else $error("interrupt released without key");
   chk_int_pin: assert property (config_int_pending [*2] |->
      !conversion_ready_pin_out && conversion_ready_pin_oe)
      else $error("pin not held low by interrupt");
   chk_int_clear: assert property (config_int_pending && lock_key == LOCK_PASSWORD &&
      !checksum_error |-> ##[1:3] !config_int_pending)
      else $error("interrupt not cleared by key");
   // ready pulse shape and delay
   chk_pulse_low: assert property ($fell(conversion_ready_pin_out) |->
      (!conversion_ready_pin_out && conversion_ready_pin_oe) [*4])
      else $error("ready pulse too short");
   chk_gain_quiet: assert property (gain_correction_enable && conv_done != 3'h0 &&
      !config_int_pending |=> (conversion_ready_pin_out || !conversion_ready_pin_oe) [*8])
      else $error("ready pulse not delayed");
endmodule
bind afe_status_config_regs afe_regs_checker i_chk (.clk(clk), .rstn(rstn),
   .cmd_start(cmd_start), .cmd_addr(cmd_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .addr_ptr(addr_ptr), .conv_done(conv_done), .checksum_error(checksum_error),
   .lock_key(lock_key), .data_word_bits(data_word_bits), .crc_field_bits(crc_field_bits),
   .gain_correction_enable(gain_correction_enable),
   .modulator_digital_clock(modulator_digital_clock),
   .config_int_pending(config_int_pending),
   .conversion_ready_pin_out(conversion_ready_pin_out),
   .conversion_ready_pin_oe(conversion_ready_pin_oe));
`default_nettype wire

// [verif/afe_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module afe_host_model
   import afe_pkg::*;
(
   input wire logic clk,
   output logic cmd_start,
   output logic [afe_pkg::ADDR_W-1:0] cmd_addr,
   output logic reg_wr,
   output logic [afe_pkg::REG_W-1:0] reg_wdata,
   output logic reg_rd
);
   import afe_pkg::*;
   // quiet bus at time zero
   initial begin
      cmd_start = 1'b0;
      cmd_addr = 5'h00;
      reg_wr = 1'b0;
      reg_wdata = 24'h000000;
      reg_rd = 1'b0;
   end
   // one strobe per cycle, changed just after an edge
   task start(input logic [4:0] a);
      @(posedge clk);
      {cmd_start, reg_wr, reg_rd} <= 3'b100;
      cmd_addr <= a;
   endtask
   task wr(input logic [23:0] d);
      @(posedge clk);
      {cmd_start, reg_wr, reg_rd} <= 3'b010;
      reg_wdata <= d;
   endtask
   task rd();
      @(posedge clk);
      {cmd_start, reg_wr, reg_rd} <= 3'b001;
   endtask
   task idle(input int k);
      repeat (k) begin
         @(posedge clk);
         {cmd_start, reg_wr, reg_rd} <= 3'b000;
      end
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
   import afe_pkg::*;
   logic clk, rstn, cmd_start, reg_wr, reg_rd, checksum_error, rd_q;
   logic [ADDR_W-1:0] cmd_addr, addr_ptr;
   logic [REG_W-1:0] reg_wdata, reg_rdata, v;
   logic [NCH-1:0] conv_done;
   logic [7:0] lock_key, reference_tempco_trim;
   logic [23:0] sample_in;
   logic [31:0] sample_word;
   logic [5:0] data_word_bits, crc_field_bits;
   logic comm_checksum_enable, offset_correction_enable, gain_correction_enable;
   logic [1:0] idle_tone_noise_level, bias_current_select;
   logic [2:0] oversampling_ratio;
   logic analog_sample_clock, modulator_digital_clock, config_int_pending;
   logic conversion_ready_pin_out, conversion_ready_pin_oe;
   logic [47:0] exp_q[$];
   logic [47:0] e;
   logic [4:0] sa[4] = '{5'h0C, 5'h0F, 5'h07, 5'h1F};
   logic [4:0] ea[4] = '{5'h0C, 5'h09, 5'h01, 5'h01};
   logic [5:0] dwb[4] = '{6'd16, 6'd24, 6'd32, 6'd32};
   int n_mismatch = 0, compares = 0, tcnt = 0, n_am = 0, n = 0;
   afe_status_config_regs i_afe_status_config_regs (.clk(clk), .rstn(rstn),
      .cmd_start(cmd_start), .cmd_addr(cmd_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_ptr(addr_ptr), .conv_done(conv_done),
      .checksum_error(checksum_error), .lock_key(lock_key), .sample_in(sample_in),
      .sample_word(sample_word), .data_word_bits(data_word_bits),
      .crc_field_bits(crc_field_bits), .comm_checksum_enable(comm_checksum_enable),
      .offset_correction_enable(offset_correction_enable),
      .gain_correction_enable(gain_correction_enable),
      .idle_tone_noise_level(idle_tone_noise_level), .bias_current_select(bias_current_select),
      .oversampling_ratio(oversampling_ratio), .reference_tempco_trim(reference_tempco_trim),
      .analog_sample_clock(analog_sample_clock),
      .modulator_digital_clock(modulator_digital_clock),
      .config_int_pending(config_int_pending),
      .conversion_ready_pin_out(conversion_ready_pin_out),
      .conversion_ready_pin_oe(conversion_ready_pin_oe));
   afe_host_model u_host (.clk(clk), .cmd_start(cmd_start), .cmd_addr(cmd_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // read results against the oldest note
   always @(posedge clk) begin
      if (rd_q === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(reg_rdata & e[47:24], e[23:0] & e[47:24])
      end
      rd_q <= reg_rd;
   end
   // analog tick count and run limit
   always @(posedge clk) begin
      tcnt++;
      if (analog_sample_clock === 1'b1) n_am++;
      if (tcnt == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // status word with reserved bits kept zero
   function automatic logic [23:0] st(input logic [9:0] f);
      return {f, 14'h0000};
   endfunction
   // expected output word for a data width code
   function automatic logic [31:0] fw(input logic [23:0] s, input logic [1:0] k);
      case (k)
         2'b11: return {{8{s[23]}}, s};
         2'b10: return {s, 8'h00};
         2'b01: return {8'h00, s};
         default: return {16'h0000, s[23:8] + 16'(s[7] && s[23:8] != 16'h7FFF)};
      endcase
   endfunction
   task automatic wreg(input logic [4:0] a, input logic [23:0] d);
      u_host.start(a);
      u_host.wr(d);
      u_host.idle(1);
      #1;
   endtask
   task automatic rdx(input logic [4:0] a, input logic [23:0] x, input logic [23:0] m);
      u_host.start(a);
      exp_q.push_back({m, x});
      u_host.rd();
      u_host.idle($urandom_range(1, 3));
      #1;
   endtask
   task automatic pulse(input logic [2:0] c);
      @(posedge clk);
      conv_done <= c;
      @(posedge clk);
      conv_done <= 3'b000;
   endtask
   task automatic wlow();
      n = 0;
      while (conversion_ready_pin_out !== 1'b0 && n < 300) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic pulse_err();
      checksum_error <= 1'b1;
      cyc(1);
      checksum_error <= 1'b0;
      cyc(20);
   endtask
   task stop_test();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {rstn, checksum_error, conv_done, lock_key, sample_in} = '0;
      n = $urandom(32'hEC18F062);
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      cyc(4);
      // reset state
      rdx(ADDR_STATUS, STATUS_RST, 24'hFFFFFF);
      rdx(ADDR_CFG0, CFG0_RST, 24'hFFFFFF);
      `CHK(conversion_ready_pin_oe, 1'b0)
      `CHK(data_word_bits, 6'd24)
      `CHK(crc_field_bits, CRC_BITS_SHORT)
      `CHK({comm_checksum_enable, offset_correction_enable, gain_correction_enable}, 3'b000)
      // read pointer in every mode, two reads from an edge address
      for (int m = 0; m < 4; m++) begin
         wreg(ADDR_STATUS, st({m[1:0], 8'hA4}));
         u_host.start(sa[m]);
         exp_q.push_back(48'h0);
         u_host.rd();
         exp_q.push_back(48'h0);
         u_host.rd();
         u_host.idle(1);
         #1;
         `CHK(addr_ptr, ea[m])
      end
      // write pointer advance, wrap and hold
      v = $urandom & 24'hBFE0FF;
      u_host.start(ADDR_STATUS);
      u_host.wr(st({2'b10, 8'hA4}));
      u_host.wr(v);
      u_host.idle(1);
      rdx(ADDR_CFG0, v, 24'hFFFFFF);
      wreg(5'h1F, 24'h000000);
      `CHK(addr_ptr, WR_FIRST)
      wreg(ADDR_STATUS, st({2'b10, 8'h24}));
      u_host.start(ADDR_CFG0);
      u_host.wr(v ^ 24'h0000FF);
      u_host.wr(v);
      u_host.idle(1);
      #1;
      `CHK(addr_ptr, ADDR_CFG0)
      rdx(ADDR_CFG0, v, 24'hFFFFFF);
      wreg(ADDR_STATUS, st({2'b10, 8'hA4}));
      // config fields and prescaler rate
      for (int p = 0; p < 4; p++) begin
         v = ($urandom & 24'hBCE0FF) | {6'h00, p[1:0], 16'h0000};
         wreg(ADDR_CFG0, v);
         `CHK({offset_correction_enable, gain_correction_enable}, v[23:22])
         `CHK({idle_tone_noise_level, bias_current_select}, v[21:18])
         `CHK({oversampling_ratio, reference_tempco_trim}, {v[15:13], v[7:0]})
         cyc(8);
         n_am = 0;
         cyc(80);
         `CHK(n_am, 80 >> p)
      end
      // checksum and data word widths
      for (int c = 0; c < 8; c++) begin
         sample_in <= 24'($urandom);
         wreg(ADDR_STATUS, st({5'b10101, c[2], c[1:0], c[0], 1'b0}));
         cyc(2);
         `CHK(crc_field_bits, c[2] ? CRC_BITS_LONG : CRC_BITS_SHORT)
         `CHK(data_word_bits, dwb[c[1:0]])
         `CHK(comm_checksum_enable, c[0])
         `CHK(sample_word, fw(sample_in, c[1:0]))
      end
      // per-channel pulse, flags and idle drive
      wreg(ADDR_CFG0, CFG0_RST);
      wreg(ADDR_STATUS, st({2'b10, 8'hC4}));
      pulse(3'b010);
      wlow();
      `CHK({conversion_ready_pin_oe, n < 5}, 2'b11)
      cyc(6);
      `CHK({conversion_ready_pin_out, conversion_ready_pin_oe}, 2'b11)
      rdx(ADDR_STATUS, st({2'b10, 8'hC4}) | 24'h5, 24'hFFFFFF);
      rdx(ADDR_STATUS, st({2'b10, 8'hC4}) | 24'h7, 24'hFFFFFF);
      pulse(3'b001);
      cyc(8);
      rdx(5'h00, 24'h0, 24'h0);
      rdx(ADDR_STATUS, st({2'b10, 8'hC4}) | 24'h6, 24'hFFFFFF);
      // merged pulse waits for the last channel
      wreg(ADDR_STATUS, st({2'b10, 8'hE4}));
      pulse(3'b001);
      pulse(3'b010);
      cyc(8);
      `CHK(conversion_ready_pin_out, 1'b1)
      pulse(3'b100);
      wlow();
      `CHK(n < 5, 1'b1)
      cyc(6);
      rdx(ADDR_STATUS, st({2'b10, 8'hE4}), 24'hFFFFFF);
      wreg(ADDR_STATUS, st({2'b10, 8'h84}));
      cyc(2);
      `CHK(conversion_ready_pin_oe, 1'b0)
      // gain correction delays the pulse
      wreg(ADDR_STATUS, st({2'b10, 8'hC4}));
      wreg(ADDR_CFG0, CFG0_RST | 24'h400000);
      pulse(3'b001);
      wlow();
      `CHK(n > 88 && n < 104, 1'b1)
      cyc(6);
      wreg(ADDR_CFG0, CFG0_RST);
      // checksum interrupt off, then on and released by key
      pulse_err();
      `CHK({config_int_pending, conversion_ready_pin_out}, 2'b01)
      wreg(ADDR_STATUS, st({2'b10, 8'hC5}));
      lock_key <= 8'($urandom_range(0, 164)); // any key below the password
      pulse_err();
      `CHK({config_int_pending, conversion_ready_pin_out}, 2'b10)
      lock_key <= LOCK_PASSWORD;
      cyc(3);
      `CHK(config_int_pending, 1'b0)
      cyc(6);
      `CHK(conversion_ready_pin_out, 1'b1)
      stop_test();
   end
endmodule
`default_nettype wire
